/* inc/frs_defines.vh */
// Constants for the fault restart supervisor: fault codes, timing counts,
// and reset values of the configuration-facing state.
// Assumes a 100 MHz ref_clk and a one-second tick made inside the block.
`ifndef FRS_DEFINES_VH
`define FRS_DEFINES_VH

// Clock rate in Hz and the tick period in seconds.
`define FRS_CLK_HZ            100000000
`define FRS_TICK_S            1
// Clock cycles in one second (one second of tick period).
`define FRS_TICK_CYCLES       (`FRS_CLK_HZ * `FRS_TICK_S)
// Two-key hold time that skips a countdown, in seconds.
`define FRS_SKIP_HOLD_S       8'h01
// Two-key hold time that clears a latched fault, in seconds.
`define FRS_CLEAR_HOLD_S      8'h03

// Fault codes shown on the display (0 means no fault).
`define FRS_CODE_NONE         8'h00
`define FRS_CODE_GROUND       8'h01
`define FRS_CODE_PRECHARGE    8'h02
`define FRS_CODE_HIGH_VOLT    8'h03
`define FRS_CODE_LOW_VOLT     8'h04
`define FRS_CODE_ALARM        8'h05
`define FRS_CODE_CONTACT1     8'h06
`define FRS_CODE_GENERIC      8'h10

// Reset values of settings.
`define FRS_ALLOW_RST         8'h00
`define FRS_ENABLE_RST        1'b1

// Supervisor states.
`define FRS_ST_INIT           3'h0
`define FRS_ST_RUN            3'h1
`define FRS_ST_COUNT          3'h2
`define FRS_ST_CONFIRM        3'h3
`define FRS_ST_LATCHED        3'h4

`endif

/* verilog/frs_hold_timer.v */
// Counts whole seconds that a level has been held, saturating at 255.
// Assumes tick is a one-cycle pulse once per second from the same clock.
`timescale 1ns/100ps

module frs_hold_timer (
    input  wire       ref_clk,   // System clock.
    input  wire       rst,       // Synchronous reset, active high.
    input  wire       tick,      // One-second pulse.
    input  wire       level,     // Level being timed.
    output reg  [7:0] secs_r     // Whole seconds held so far.
);

    // Releasing the level restarts the count, so a hold must be unbroken.
    always @(posedge ref_clk) begin
        if (rst || !level) begin
            secs_r <= 8'h00;
        end else if (tick && secs_r != 8'hFF) begin
            secs_r <= secs_r + 8'h01;
        end
    end

endmodule // frs_hold_timer

/* verilog/frs_supervisor.v */
// Fault restart supervisor: shows the active fault, runs the auto-restart
// countdown, counts restarts against the allowance and keeps a restart log.
// Assumes all inputs are synchronous to ref_clk and already debounced, and
// that rst stands for a power cycle.
`timescale 1ns/100ps
`include "frs_defines.vh"

module frs_supervisor (
    input  wire       ref_clk,               // 100 MHz clock.
    input  wire       rst,                   // Sync reset, power-on.
    input  wire       gen_fault,             // Other restartable fault.
    input  wire       gen_fault_latched,     // Other non-restartable fault.
    input  wire       ground_fault,          // Ground fault detected.
    input  wire       precharge_fail,        // Precharge failed.
    input  wire       high_voltage,          // Input voltage high.
    input  wire       low_voltage,           // Input voltage low.
    input  wire       alarm_active,          // An alarm is present.
    input  wire       alarm_as_fault,        // Warning menu: alarm is fault.
    input  wire       contact_input_one,     // Contact 1 closed.
    input  wire       contact_input_two,     // Contact 2 closed.
    input  wire       contact_input_three,   // Contact 3 closed.
    input  wire       contact_input_four,    // Contact 4 closed.
    input  wire       key_up,                // UP arrow held.
    input  wire       key_down,              // DOWN arrow held.
    input  wire       key_enter,             // ENTER pulse.
    input  wire       clear_memory,          // Clear-memory command pulse.
    input  wire       restart_enable,        // Restart enable setting.
    input  wire [7:0] restart_allowance_setting, // Allowed restarts.
    input  wire [7:0] restart_delay_setting, // Seconds before restart.
    output reg  [7:0] fault_code_r,          // Active fault code, 0 none.
    output reg  [7:0] countdown_r,           // Seconds left to restart.
    output reg        countdown_shown_r,     // Countdown on display.
    output reg        no_auto_restart_r,     // No-auto-restart indication.
    output reg        confirm_prompt_r,      // Confirm-restart prompt.
    output reg        run_r,                 // Load may run.
    output reg        auto_mode_r,           // Came up in auto mode.
    output reg  [7:0] restart_count_r,       // Restarts since last clear.
    output reg  [7:0] restart_log_r,         // Logged restartable faults.
    output reg        init_done_r            // Power-up init finished.
);

    reg [26:0] tick_cnt_r;   // Divider for the one-second tick.
    reg        tick_r;       // One-cycle pulse each second.
    reg [2:0]  state_r;      // Supervisor state.
    reg [2:0]  state_nxt;    // Next supervisor state.
    reg        first_r;      // High until the first cycle after reset.
    wire [7:0] hold_secs;    // Seconds both arrows have been held.
    wire       both_arrows;  // UP and DOWN held together.
    wire       init_cond;    // Any init-time supply fault.
    wire       alarm_fault;  // Alarm escalated to a fault.
    wire [3:0] contacts;     // Contact inputs as a vector.
    wire       latch_src;    // Any non-restartable source.
    wire       restart_src;  // Any restartable source.
    reg  [7:0] code_src;     // Code of the highest-priority source.

    assign both_arrows = key_up & key_down;
    assign init_cond   = ground_fault | precharge_fail | high_voltage |
                         low_voltage;
    assign alarm_fault = alarm_active & alarm_as_fault;
    assign contacts    = {contact_input_four, contact_input_three,
                          contact_input_two, contact_input_one};
    assign latch_src   = gen_fault_latched | (|contacts);
    assign restart_src = gen_fault | alarm_fault | init_cond;

    // One hold timer serves both the skip and the clear gestures.
    frs_hold_timer u_hold (
        .ref_clk (ref_clk),
        .rst     (rst),
        .tick    (tick_r),
        .level   (both_arrows),
        .secs_r  (hold_secs)
    );

    // The tick divider; the full count is too long for short simulations
    // but the spacing is fixed by the clock rate.
    always @(posedge ref_clk) begin
        if (rst || tick_cnt_r == `FRS_TICK_CYCLES - 1) begin
            tick_cnt_r <= 27'h0000000;
        end else begin
            tick_cnt_r <= tick_cnt_r + 27'h0000001;
        end
    end

    // Tick pulse is registered so the timers see a clean single cycle.
    always @(posedge ref_clk) begin
        if (rst) begin
            tick_r <= 1'b0;
        end else begin
            tick_r <= (tick_cnt_r == `FRS_TICK_CYCLES - 1);
        end
    end

    // Priority encoder: latched sources first, since they must win.
    always @* begin
        if (contacts[0]) begin
            code_src = `FRS_CODE_CONTACT1;
        end else if (contacts[1]) begin
            code_src = `FRS_CODE_CONTACT1 + 8'h01;
        end else if (contacts[2]) begin
            code_src = `FRS_CODE_CONTACT1 + 8'h02;
        end else if (contacts[3]) begin
            code_src = `FRS_CODE_CONTACT1 + 8'h03;
        end else if (gen_fault_latched) begin
            code_src = `FRS_CODE_GENERIC + 8'h01;
        end else if (ground_fault) begin
            code_src = `FRS_CODE_GROUND;
        end else if (precharge_fail) begin
            code_src = `FRS_CODE_PRECHARGE;
        end else if (high_voltage) begin
            code_src = `FRS_CODE_HIGH_VOLT;
        end else if (low_voltage) begin
            code_src = `FRS_CODE_LOW_VOLT;
        end else if (alarm_fault) begin
            code_src = `FRS_CODE_ALARM;
        end else if (gen_fault) begin
            code_src = `FRS_CODE_GENERIC;
        end else begin
            code_src = `FRS_CODE_NONE;
        end
    end

    // Decide whether a new restartable fault counts down or prompts.
    wire can_auto = restart_enable &&
                    (restart_count_r < restart_allowance_setting);

    // Next-state logic.
    always @* begin
        state_nxt = state_r;
        case (state_r)
            `FRS_ST_INIT: begin
                // Wait for supply faults to resolve before running.
                if (latch_src) begin
                    state_nxt = `FRS_ST_LATCHED;
                end else if (!init_cond && !first_r) begin
                    state_nxt = `FRS_ST_RUN;
                end
            end
            `FRS_ST_RUN: begin
                if (latch_src) begin
                    state_nxt = `FRS_ST_LATCHED;
                end else if (restart_src) begin
                    state_nxt = can_auto ? `FRS_ST_COUNT
                                         : `FRS_ST_CONFIRM;
                end
            end
            `FRS_ST_COUNT: begin
                if (latch_src) begin
                    state_nxt = `FRS_ST_LATCHED;
                end else if (both_arrows &&
                             hold_secs >= `FRS_SKIP_HOLD_S) begin
                    // The timer output lags by one edge, so the keys must
                    // still be down when the skip is taken.
                    state_nxt = `FRS_ST_RUN;
                end else if (countdown_r == 8'h00) begin
                    state_nxt = `FRS_ST_RUN;
                end
            end
            `FRS_ST_CONFIRM: begin
                if (latch_src) begin
                    state_nxt = `FRS_ST_LATCHED;
                end else if (key_enter) begin
                    state_nxt = `FRS_ST_RUN;
                end
            end
            `FRS_ST_LATCHED: begin
                // Only the long two-key hold (or reset) leaves this state.
                // A contact that is still closed keeps the fault standing.
                if (both_arrows && !latch_src &&
                    hold_secs >= `FRS_CLEAR_HOLD_S) begin
                    state_nxt = `FRS_ST_RUN;
                end
            end
            default: begin
                state_nxt = `FRS_ST_INIT;
            end
        endcase
    end

    // State register and the flag that marks the first cycle after reset.
    always @(posedge ref_clk) begin
        if (rst) begin
            state_r <= `FRS_ST_INIT;
            first_r <= 1'b1;
        end else begin
            state_r <= state_nxt;
            first_r <= 1'b0;
        end
    end

    // Countdown: loaded from the delay setting on entry, then one per tick.
    always @(posedge ref_clk) begin
        if (rst) begin
            countdown_r <= 8'h00;
        end else if (state_r != `FRS_ST_COUNT) begin
            countdown_r <= restart_delay_setting;
        end else if (tick_r && countdown_r != 8'h00) begin
            countdown_r <= countdown_r - 8'h01;
        end
    end

    // Restart counter and log. Clear-memory and the confirm path both
    // zero the counters; a logged fault in the same cycle still counts.
    always @(posedge ref_clk) begin
        if (rst) begin
            restart_count_r <= `FRS_ALLOW_RST;
            restart_log_r   <= 8'h00;
        end else begin
            if (clear_memory || (state_r == `FRS_ST_CONFIRM &&
                                 state_nxt == `FRS_ST_RUN)) begin
                restart_count_r <= 8'h00;
                restart_log_r   <= 8'h00;
            end else if (state_r == `FRS_ST_COUNT &&
                         state_nxt == `FRS_ST_RUN &&
                         restart_count_r != 8'hFF) begin
                restart_count_r <= restart_count_r + 8'h01;
            end
            // Restartable faults seen in RUN are logged; init-time ones never reach RUN.
            if (state_r == `FRS_ST_RUN && !latch_src && restart_src &&
                restart_log_r != 8'hFF) begin
                restart_log_r <= (clear_memory ? 8'h00 : restart_log_r)
                                 + 8'h01;
            end
        end
    end

    // Display and drive outputs, all registered; all but the fault code and auto_mode_r come from the next state.
    always @(posedge ref_clk) begin
        if (rst) begin
            fault_code_r      <= `FRS_CODE_NONE;
            countdown_shown_r <= 1'b0;
            no_auto_restart_r <= 1'b0;
            confirm_prompt_r  <= 1'b0;
            run_r             <= 1'b0;
            auto_mode_r       <= 1'b0;
            init_done_r       <= 1'b0;
        end else begin
            // Show the live code while any source is present.
            fault_code_r      <= code_src;
            countdown_shown_r <= (state_nxt == `FRS_ST_COUNT);
            no_auto_restart_r <= (state_nxt == `FRS_ST_LATCHED);
            confirm_prompt_r  <= (state_nxt == `FRS_ST_CONFIRM);
            run_r             <= (state_nxt == `FRS_ST_RUN);
            // Init also ends when a latched fault taken during init clears.
            if (!init_done_r && state_nxt == `FRS_ST_RUN) begin
                init_done_r <= 1'b1;
                auto_mode_r <= restart_enable;
            end
        end
    end

endmodule // frs_supervisor

/* bench/frs_supervisor_props.sv */
// Port-level checker for the fault restart supervisor.
// Assumes one clock domain and a synchronous active-high reset.
`timescale 1ns/100ps
`include "frs_defines.vh"
module frs_supervisor_props (
    input wire       ref_clk, rst, gen_fault, gen_fault_latched,
    input wire       ground_fault, precharge_fail, high_voltage,
    input wire       low_voltage, alarm_active, alarm_as_fault,
    input wire       contact_input_one, contact_input_two,
    input wire       contact_input_three, contact_input_four,
    input wire       key_up, key_down, key_enter, clear_memory,
    input wire       restart_enable, countdown_shown_r, run_r,
    input wire       no_auto_restart_r, confirm_prompt_r, init_done_r,
    input wire [7:0] restart_allowance_setting, restart_delay_setting,
    input wire [7:0] fault_code_r, countdown_r, restart_count_r,
    input wire [7:0] restart_log_r
);
    // Latched sources win over every restartable one.
    wire lat = gen_fault_latched | contact_input_one | contact_input_two |
               contact_input_three | contact_input_four;
    wire sup = ground_fault | precharge_fail | high_voltage | low_voltage;
    wire alm = alarm_active & alarm_as_fault;
    wire any = lat | sup | alm | gen_fault;
    // Restart allowance used up, or restarts switched off.
    wire spent = !restart_enable ||
                 (restart_count_r >= restart_allowance_setting);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_fault_shown: assert property (any |=> fault_code_r != 8'h00)
        else $error("fault present but no code shown");
    a_latch_stops: assert property (lat |=> no_auto_restart_r && !run_r)
        else $error("latched fault did not stop the load");
    a_latch_holds: assert property (no_auto_restart_r && !(key_up && key_down)
        |=> no_auto_restart_r)
        else $error("latched fault cleared without a long hold");
    a_count_no_run: assert property (countdown_shown_r |-> !run_r)
        else $error("load runs during countdown");
    a_auto_start: assert property (run_r && gen_fault && !lat && !spent
        |=> countdown_shown_r && countdown_r == $past(restart_delay_setting))
        else $error("countdown not started with the delay");
    a_prompt_spent: assert property (run_r && gen_fault && !lat && spent
        |=> confirm_prompt_r && !run_r)
        else $error("confirm prompt missing");
    a_log_counts: assert property (run_r && gen_fault && !lat && !clear_memory
        |=> restart_log_r == $past(restart_log_r) + 8'h01)
        else $error("restart log not advanced");
    a_enter_clears: assert property (confirm_prompt_r && key_enter && !any
        |=> run_r && restart_count_r == 8'h00 && restart_log_r == 8'h00)
        else $error("enter did not restart and zero counters");
    a_clear_memory: assert property (confirm_prompt_r && clear_memory
        && !key_enter |=> restart_log_r == 8'h00)
        else $error("clear memory left the log");
    a_init_silent: assert property (!init_done_r && !clear_memory
        |=> $stable(restart_log_r))
        else $error("log changed during init");
    a_alarm_fault: assert property (alm && !(lat | sup | gen_fault)
        |=> fault_code_r == `FRS_CODE_ALARM)
        else $error("alarm escalation code missing");
    c_count: cover property (countdown_shown_r);
    c_enter: cover property (confirm_prompt_r && key_enter);
    c_latch: cover property (no_auto_restart_r);
endmodule // frs_supervisor_props
bind frs_supervisor frs_supervisor_props u_props (.*);

/* bench/frs_operator_model.sv */
// Keypad operator and auxiliary dry contacts facing the supervisor.
// Assumes the bench calls its tasks; lines change 1 ns after an edge.
`timescale 1ns/100ps
module frs_operator_model (
    input  wire       ref_clk,   // System clock.
    output reg        key_up,    // UP arrow held.
    output reg        key_down,  // DOWN arrow held.
    output reg        key_enter, // ENTER pressed.
    output reg  [3:0] contacts   // Dry contacts, bit 0 is input one.
);
    initial begin
        {key_up, key_down, key_enter, contacts} = 7'h00;
    end
    // One-cycle ENTER press.
    task press_enter;
        begin
            @(posedge ref_clk) #1 key_enter = 1'b1;
            @(posedge ref_clk) #1 key_enter = 1'b0;
        end
    endtask
    // A dry contact closes or opens; a closure is the fault event.
    task set_contact(input integer idx, input reg val);
        begin
            @(posedge ref_clk) #1 contacts[idx] = val;
        end
    endtask
    // Both arrows for n clocks; far shorter than a second on purpose.
    task hold_arrows(input integer n);
        begin
            @(posedge ref_clk) #1 {key_up, key_down} = 2'h3;
            repeat (n) @(posedge ref_clk);
            #1 {key_up, key_down} = 2'h0;
        end
    endtask
endmodule // frs_operator_model

/* bench/test_fault_restart_supervisor.sv */
// Self-checking bench for the fault restart supervisor.
// Assumes the checker is bound in and the operator model drives the keys.
`timescale 1ns/100ps
`include "frs_defines.vh"
module test_fault_restart_supervisor;
    reg ref_clk, rst, gen_fault, gen_fault_latched, ground_fault;
    reg precharge_fail, high_voltage, low_voltage, alarm_active;
    reg alarm_as_fault, clear_memory, restart_enable;
    reg [7:0] restart_allowance_setting, restart_delay_setting;
    wire key_up, key_down, key_enter, countdown_shown_r, no_auto_restart_r;
    wire confirm_prompt_r, run_r, auto_mode_r, init_done_r;
    wire [3:0] contacts;
    wire [7:0] fault_code_r, countdown_r, restart_count_r, restart_log_r;
    wire contact_input_one = contacts[0];
    wire contact_input_two = contacts[1];
    wire contact_input_three = contacts[2];
    wire contact_input_four = contacts[3];
    integer miscompares = 0, compares = 0, seed = 32'hfd1cce26, i;
    frs_supervisor DUT (.*);
    frs_operator_model u_op (.ref_clk(ref_clk), .key_up(key_up),
        .key_down(key_down), .key_enter(key_enter), .contacts(contacts));
    initial begin
        ref_clk = 1'b0;
        forever #5 ref_clk = ~ref_clk;
    end
    // Compare one value and count the result.
    task chk(input string name, input [7:0] seen, input [7:0] exp);
        begin
            compares = compares + 1;
            if (seen !== exp) begin
                miscompares = miscompares + 1;
                $display("mismatch %s exp %h seen %h", name, exp, seen);
            end
        end
    endtask
    // Step n edges, landing just after the last one.
    task cyc(input integer n);
        begin
            repeat (n) @(posedge ref_clk);
            #1;
        end
    endtask
    // Power cycle: sixteen clocks of reset.
    task do_reset;
        begin
            rst = 1'b1;
            cyc(16);
            rst = 1'b0;
        end
    endtask
    // Display code expected for contact input idx.
    function [7:0] contact_code(input integer idx);
        contact_code = `FRS_CODE_CONTACT1 + idx[7:0];
    endfunction
    task end_sim;
        begin
            $display("compares %0d miscompares %0d", compares, miscompares);
            if (miscompares == 0 && compares > 0)
                $display("ALL CHECKS OK");
            else
                $display("CHECKS NOT OK");
            $finish;
        end
    endtask
    // Watchdog: the tests need well under five thousand clocks.
    initial begin
        repeat (5000) @(posedge ref_clk);
        miscompares = miscompares + 1;
        end_sim;
    end
    initial begin
        {rst, gen_fault, gen_fault_latched, precharge_fail} = 4'h0;
        {high_voltage, low_voltage, alarm_active, alarm_as_fault} = 4'h0;
        {clear_memory, restart_enable, ground_fault} = 3'h3;
        restart_allowance_setting = `FRS_ALLOW_RST;
        restart_delay_setting = 8'h05;
        do_reset;
        cyc(4);
        chk("code", fault_code_r, `FRS_CODE_GROUND);
        chk("init", init_done_r, 8'h00);
        ground_fault = 1'b0;
        cyc(4);
        chk("init", init_done_r, 8'h01);
        chk("log", restart_log_r, 8'h00);
        chk("auto", auto_mode_r, 8'h01);
        $display("test init done");
        low_voltage = 1'b1;
        cyc(1);
        chk("code", fault_code_r, `FRS_CODE_LOW_VOLT);
        chk("prompt", confirm_prompt_r, 8'h01);
        chk("log", restart_log_r, 8'h01);
        low_voltage = 1'b0;
        clear_memory = 1'b1;
        cyc(1);
        clear_memory = 1'b0;
        chk("log", restart_log_r, 8'h00);
        u_op.press_enter;
        chk("run", run_r, 8'h01);
        chk("count", restart_count_r, 8'h00);
        $display("test confirm done");
        restart_allowance_setting = 8'h01 + 8'({$random(seed)} % 200);
        restart_delay_setting = 8'h02 + 8'({$random(seed)} % 200);
        gen_fault = 1'b1;
        cyc(1);
        gen_fault = 1'b0;
        chk("shown", countdown_shown_r, 8'h01);
        chk("delay", countdown_r, restart_delay_setting);
        chk("run", run_r, 8'h00);
        u_op.hold_arrows(10);
        chk("shown", countdown_shown_r, 8'h01);
        $display("test countdown done");
        restart_enable = 1'b0;
        do_reset;
        cyc(3);
        chk("auto", auto_mode_r, 8'h00);
        gen_fault = 1'b1;
        cyc(1);
        gen_fault = 1'b0;
        chk("prompt", confirm_prompt_r, 8'h01);
        u_op.press_enter;
        restart_enable = 1'b1;
        alarm_active = 1'b1;
        cyc(2);
        chk("code", fault_code_r, `FRS_CODE_NONE);
        alarm_as_fault = 1'b1;
        cyc(1);
        chk("code", fault_code_r, `FRS_CODE_ALARM);
        {alarm_active, alarm_as_fault} = 2'h0;
        $display("test enable and alarm done");
        for (i = 0; i < 4; i = i + 1) begin
            do_reset;
            cyc(3);
            u_op.set_contact(i, 1'b1);
            cyc(1);
            chk("code", fault_code_r, contact_code(i));
            chk("noauto", no_auto_restart_r, 8'h01);
            u_op.set_contact(i, 1'b0);
            u_op.hold_arrows(20);
            u_op.press_enter;
            cyc(2);
            chk("noauto", no_auto_restart_r, 8'h01);
            chk("run", run_r, 8'h00);
        end
        do_reset;
        cyc(3);
        chk("noauto", no_auto_restart_r, 8'h00);
        restart_delay_setting = 8'h00;
        restart_allowance_setting = 8'h01;
        gen_fault = 1'b1;
        cyc(1);
        gen_fault = 1'b0;
        cyc(1);
        chk("run", run_r, 8'h01);
        chk("count", restart_count_r, 8'h01);
        gen_fault = 1'b1;
        cyc(1);
        gen_fault = 1'b0;
        chk("prompt", confirm_prompt_r, 8'h01);
        $display("test contacts done");
        end_sim;
    end
endmodule // test_fault_restart_supervisor
